/* hw/txd_exec.sv */
// Execute engine for exception call and return, custom ops, control write and exclusive-OR
`default_nettype none
module txd_exec
	import txd_pkg::*;
#(
	parameter logic [TXD_DW-1:0] P_VEC_BASE_RST = 32'h0000_0000
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_insn_valid,
	input wire logic [15:0] i_insn,
	input wire logic [TXD_DW-1:0] i_pc,
	input wire logic i_prefix_valid,
	input wire logic [TXD_PREFIX_W-1:0] i_prefix,
	input wire logic [TXD_DW-1:0] i_vec_base,
	output logic o_insn_ready,
	output logic [TXD_REG_W-1:0] o_rf_raddr_a,
	output logic [TXD_REG_W-1:0] o_rf_raddr_b,
	input wire logic [TXD_DW-1:0] i_rf_rdata_a,
	input wire logic [TXD_DW-1:0] i_rf_rdata_b,
	input wire logic [TXD_DW-1:0] i_rf_rdata_r0,
	output logic o_rf_we,
	output logic [TXD_REG_W-1:0] o_rf_waddr,
	output logic [TXD_DW-1:0] o_rf_wdata,
	output logic o_vec_rd,
	output logic [TXD_DW-1:0] o_vec_addr,
	input wire logic i_vec_ack,
	input wire logic [TXD_DW-1:0] i_vec_rdata,
	output logic o_pc_we,
	output logic [TXD_DW-1:0] o_pc_wdata,
	output txd_cust_req_type o_cust_req,
	input wire logic i_cust_done,
	input wire logic [TXD_DW-1:0] i_cust_result,
	output logic o_ctl_we,
	output logic [TXD_PREFIX_W-1:0] o_ctl_idx,
	output logic [TXD_DW-1:0] o_ctl_wdata,
	output logic [TXD_DW-1:0] o_status,
	output logic [TXD_DW-1:0] o_saved_status
);
	typedef enum logic [1:0] {TXD_S_IDLE, TXD_S_VEC, TXD_S_CUST} txd_state_type;
	localparam logic [4:0] TXD_LINK_REG = 5'h0F;
	txd_dec_type dec;
	txd_state_type state_q;
	logic [TXD_DW-1:0] status_q;
	logic [TXD_DW-1:0] istat_q;
	logic [TXD_REG_W-1:0] rd_q;
	logic [TXD_DW-1:0] vaddr_q;
	logic [TXD_DW-1:0] xor_res;
	logic [TXD_DW-1:0] xor_b;
	logic [TXD_DW-1:0] ctl_val;
	logic [TXD_WPTR_W-1:0] wptr;
	logic go;
	logic is_trap;
	logic is_eret;
	logic is_xor;
	logic is_ctlwr;
	logic is_usr;
	logic ctl_to_status;
	logic ctl_to_istat;
	logic cust_q;
	txd_cust_req_type creq_q;

	txd_decode u_dec (
		.i_insn(i_insn),
		.o_dec(dec)
	);

	assign go = i_insn_valid && (state_q == TXD_S_IDLE);
	assign is_trap = go && (dec.kind == TXD_K_TRAP);
	assign is_eret = go && (dec.kind == TXD_K_ERET);
	assign is_xor = go && (dec.kind == TXD_K_XOR);
	assign is_ctlwr = go && (dec.kind == TXD_K_CTLWR);
	assign is_usr = go && (dec.kind == TXD_K_USR);
	assign o_rf_raddr_a = dec.rd;
	assign o_rf_raddr_b = dec.rs;
	assign wptr = status_q[TXD_ST_WPTR_LSB +: TXD_WPTR_W];
	// Stalls the stream while a vector fetch or custom op is open
	assign o_insn_ready = (state_q == TXD_S_IDLE) && !(i_insn_valid &&
		(dec.kind == TXD_K_TRAP || dec.kind == TXD_K_USR));
	// Prefix replaces second operand, zero extended
	assign xor_b = i_prefix_valid ? {16'h0000, i_prefix, dec.simm} : i_rf_rdata_b;
	assign xor_res = i_rf_rdata_a ^ xor_b;
	assign ctl_to_status = is_ctlwr && (!i_prefix_valid || i_prefix == TXD_CTL_STATUS);
	assign ctl_to_istat = is_ctlwr && i_prefix_valid && (i_prefix == TXD_CTL_ISTAT);
	assign ctl_val = i_rf_rdata_a;

	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			state_q <= TXD_S_IDLE;
		end else begin
			case (state_q)
				TXD_S_IDLE: begin
					if (is_trap) begin
						state_q <= TXD_S_VEC;
					end else if (is_usr) begin
						state_q <= TXD_S_CUST;
					end
				end
				TXD_S_VEC: if (i_vec_ack) state_q <= TXD_S_IDLE;
				TXD_S_CUST: if (i_cust_done) state_q <= TXD_S_IDLE;
				default: state_q <= TXD_S_IDLE;
			endcase
		end
	end

	// Status and saved status; a call is taken regardless of the enable bit
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			status_q <= TXD_STATUS_RST;
			istat_q <= TXD_STATUS_RST;
		end else if (is_trap) begin
			istat_q <= status_q;
			status_q[TXD_ST_INT_EN] <= 1'b0;
			status_q[TXD_ST_WPTR_LSB +: TXD_WPTR_W] <= wptr - 5'h01;
			status_q[TXD_ST_PRIO_LSB +: TXD_PRIO_W] <= dec.num;
		end else if (is_eret) begin
			status_q <= istat_q;
		end else if (ctl_to_status) begin
			status_q <= ctl_val;
		end else if (ctl_to_istat) begin
			istat_q <= ctl_val;
		end else if (is_xor) begin
			status_q[TXD_ST_N] <= xor_res[31];
			status_q[TXD_ST_Z] <= (xor_res == 32'h0000_0000);
		end
	end

	// Register file write port, registered
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_rf_we <= 1'b0;
			o_rf_waddr <= 5'h00;
			o_rf_wdata <= 32'h0000_0000;
		end else begin
			o_rf_we <= 1'b0;
			if (is_xor) begin
				o_rf_we <= 1'b1;
				o_rf_waddr <= dec.rd;
				o_rf_wdata <= xor_res;
			end else if (is_trap) begin
				o_rf_we <= 1'b1;
				o_rf_waddr <= TXD_LINK_REG;
				o_rf_wdata <= (i_pc + TXD_PC_STEP) >> 1;
			end else if (state_q == TXD_S_CUST && i_cust_done) begin
				o_rf_we <= 1'b1;
				o_rf_waddr <= rd_q;
				o_rf_wdata <= i_cust_result;
			end
		end
	end

	// Vector fetch and custom request
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			rd_q <= 5'h00;
			vaddr_q <= P_VEC_BASE_RST;
			creq_q <= '0;
		end else begin
			if (is_trap) begin
				vaddr_q <= i_vec_base + {24'h000000, 2'b00, dec.num} * TXD_VEC_SCALE;
			end
			if (is_usr) begin
				rd_q <= dec.rd;
				creq_q.valid <= 1'b1;
				creq_q.sel <= dec.usr_sel;
				creq_q.opa <= i_rf_rdata_a;
				// One-register forms read register zero
				creq_q.opb <= (dec.usr_sel == 3'h0) ? i_rf_rdata_b : i_rf_rdata_r0;
				creq_q.prefix_valid <= i_prefix_valid;
				creq_q.prefix <= i_prefix_valid ? i_prefix : 11'h000;
			end else if (state_q == TXD_S_CUST && i_cust_done) begin
				creq_q.valid <= 1'b0;
			end
		end
	end

	assign o_cust_req = creq_q;
	assign o_vec_rd = (state_q == TXD_S_VEC);
	assign o_vec_addr = vaddr_q;

	// PC redirect from call fetch or return
	always_ff @(posedge i_mclk) begin
		if (!i_rst_b) begin
			o_pc_we <= 1'b0;
			o_pc_wdata <= 32'h0000_0000;
			o_ctl_we <= 1'b0;
			o_ctl_idx <= 11'h000;
			o_ctl_wdata <= 32'h0000_0000;
		end else begin
			o_pc_we <= 1'b0;
			o_ctl_we <= is_ctlwr;
			if (is_ctlwr) begin
				o_ctl_idx <= i_prefix_valid ? i_prefix : TXD_CTL_STATUS;
				o_ctl_wdata <= ctl_val;
			end
			if (state_q == TXD_S_VEC && i_vec_ack) begin
				o_pc_we <= 1'b1;
				o_pc_wdata <= i_vec_rdata << 1;
			end else if (is_eret) begin
				o_pc_we <= 1'b1;
				o_pc_wdata <= i_rf_rdata_a << 1;
			end
		end
	end

	assign o_status = status_q;
	assign o_saved_status = istat_q;
endmodule
`default_nettype wire

/* inc/txd_pkg.sv */
// Package with encodings, field layouts and constants for the trap/custom/control/xor decoder
// Contract
// - Software exception call decrements the window pointer by one.
// - Call copies status into saved status, then clears the interrupt enable bit.
// - Call fetches table word at base plus number times four; PC gets it doubled.
// - Return link register gets (PC plus two) shifted right by one.
// - Call is taken even while interrupts are disabled.
// - No delay slot: following instruction not executed first; it is the return target.
// - Handler number comes from the low six bits of the instruction.
// - Exception return loads PC with the source register shifted left by one.
// - Exception return copies saved status back, restoring the window pointer.
// - Two-register custom op writes user result to first register; flags unchanged.
// - One-register custom ops use register zero as second operand.
// - A preceding prefix passes its eleven-bit value to the custom hardware.
// - Custom hardware may be single or multi cycle; stall until it reports done.
// - Control write loads status without prefix, else control register indexed by prefix.
// - Control write to status sets flags from source bits 3..0; others leave flags.
// - Unprefixed exclusive-OR combines both registers into the first register.
// - Prefixed exclusive-OR uses prefix and short immediate, zero-extended to 32 bits.
// - Exclusive-OR sets negative from bit 31 and zero flag; overflow and carry kept.
`default_nettype none
package txd_pkg;
	localparam int TXD_DW = 32;
	localparam int TXD_PREFIX_W = 11;
	localparam int TXD_NUM_W = 6;
	localparam int TXD_SIMM_W = 5;
	localparam int TXD_REG_W = 5;
	localparam int TXD_WPTR_W = 5;
	localparam int TXD_PRIO_W = 6;
	// Opcode fields
	localparam logic [5:0] TXD_OP6_XOR = 6'h11;
	localparam logic [5:0] TXD_OP6_CUST2 = 6'h1C;
	localparam logic [9:0] TXD_OP10_TRAP = 10'h1E4;
	localparam logic [10:0] TXD_OP11_ERET = 11'h3EE;
	localparam logic [10:0] TXD_OP11_CUST1 = 11'h3E9;
	localparam logic [10:0] TXD_OP11_CUST2 = 11'h3EA;
	localparam logic [10:0] TXD_OP11_CUST3 = 11'h3EB;
	localparam logic [10:0] TXD_OP11_CUST4 = 11'h3EC;
	localparam logic [10:0] TXD_OP11_CTLWR = 11'h3F8;
	// Status register layout
	localparam int TXD_ST_FLAG_LSB = 0;
	localparam int TXD_ST_N = 3;
	localparam int TXD_ST_V = 2;
	localparam int TXD_ST_Z = 1;
	localparam int TXD_ST_C = 0;
	localparam int TXD_ST_WPTR_LSB = 4;
	localparam int TXD_ST_PRIO_LSB = 9;
	localparam int TXD_ST_INT_EN = 15;
	localparam logic [TXD_DW-1:0] TXD_STATUS_RST = 32'h0000_0000;
	// Control register indices
	localparam logic [TXD_PREFIX_W-1:0] TXD_CTL_STATUS = 11'h000;
	localparam logic [TXD_PREFIX_W-1:0] TXD_CTL_ISTAT = 11'h001;
	localparam logic [TXD_DW-1:0] TXD_VEC_SCALE = 32'h0000_0004;
	localparam logic [TXD_DW-1:0] TXD_PC_STEP = 32'h0000_0002;
	typedef enum logic [2:0] {
		TXD_K_NONE, TXD_K_XOR, TXD_K_USR, TXD_K_TRAP, TXD_K_ERET, TXD_K_CTLWR
	} txd_kind_type;
	typedef struct packed {
		txd_kind_type kind;
		logic [2:0] usr_sel;
		logic [TXD_REG_W-1:0] rd;
		logic [TXD_REG_W-1:0] rs;
		logic [TXD_SIMM_W-1:0] simm;
		logic [TXD_NUM_W-1:0] num;
	} txd_dec_type;
	typedef struct packed {
		logic valid;
		logic [2:0] sel;
		logic [TXD_DW-1:0] opa;
		logic [TXD_DW-1:0] opb;
		logic prefix_valid;
		logic [TXD_PREFIX_W-1:0] prefix;
	} txd_cust_req_type;
endpackage
`default_nettype wire

/* hw/txd_decode.sv */
// Combinational field decoder for the instruction group
`default_nettype none
module txd_decode
	import txd_pkg::*;
(
	input wire logic [15:0] i_insn,
	output txd_dec_type o_dec
);
	always_comb begin
		o_dec.kind = TXD_K_NONE;
		o_dec.usr_sel = 3'h0;
		o_dec.rd = i_insn[4:0];
		o_dec.rs = i_insn[9:5];
		o_dec.simm = i_insn[9:5];
		o_dec.num = i_insn[5:0];
		if (i_insn[15:10] == TXD_OP6_XOR) begin
			o_dec.kind = TXD_K_XOR;
		end else if (i_insn[15:10] == TXD_OP6_CUST2) begin
			o_dec.kind = TXD_K_USR;
		end else if (i_insn[15:6] == TXD_OP10_TRAP) begin
			o_dec.kind = TXD_K_TRAP;
		end else begin
			case (i_insn[15:5])
				TXD_OP11_ERET: o_dec.kind = TXD_K_ERET;
				TXD_OP11_CTLWR: o_dec.kind = TXD_K_CTLWR;
				TXD_OP11_CUST1, TXD_OP11_CUST2, TXD_OP11_CUST3, TXD_OP11_CUST4: begin
					o_dec.kind = TXD_K_USR;
					o_dec.usr_sel = i_insn[7:5];
				end
				default: o_dec.kind = TXD_K_NONE;
			endcase
		end
	end
endmodule
`default_nettype wire

/* verification/txd_checker.sv */
// Assertion checker for the trap/custom/control/xor executor
`default_nettype none
module txd_checker
	import txd_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_insn_valid,
	input wire logic [15:0] i_insn,
	input wire logic [TXD_DW-1:0] i_pc,
	input wire logic [TXD_DW-1:0] i_vec_base,
	input wire logic o_insn_ready,
	input wire logic o_rf_we,
	input wire logic [TXD_REG_W-1:0] o_rf_waddr,
	input wire logic [TXD_DW-1:0] o_rf_wdata,
	input wire logic o_vec_rd,
	input wire logic [TXD_DW-1:0] o_vec_addr,
	input wire logic i_vec_ack,
	input wire logic [TXD_DW-1:0] i_vec_rdata,
	input wire logic o_pc_we,
	input wire logic [TXD_DW-1:0] o_pc_wdata,
	input wire txd_cust_req_type o_cust_req,
	input wire logic i_cust_done,
	input wire logic [TXD_DW-1:0] i_cust_result,
	input wire logic [TXD_DW-1:0] i_rf_rdata_a
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	wire logic eret = i_insn_valid && o_insn_ready && i_insn[15:5] == TXD_OP11_ERET;
	wire logic [TXD_DW-1:0] link = (i_pc + TXD_PC_STEP) >> 1;
	wire logic [TXD_DW-1:0] vadr = i_vec_base + {i_insn[5:0], 2'b00};
	link_write_a: assert property ($rose(o_vec_rd) |-> o_rf_we && o_rf_waddr == 5'hF
		&& o_rf_wdata == $past(link)) else $error("link write wrong");
	vec_addr_a: assert property ($rose(o_vec_rd) |-> o_vec_addr == $past(vadr))
		else $error("table address wrong");
	vec_hold_a: assert property (o_vec_rd && !i_vec_ack |=> o_vec_rd && $stable(o_vec_addr))
		else $error("table read dropped");
	pc_load_a: assert property (o_vec_rd && i_vec_ack |=> o_pc_we
		&& o_pc_wdata == $past(i_vec_rdata) << 1) else $error("handler pc wrong");
	no_slot_a: assert property (o_vec_rd |-> !o_insn_ready)
		else $error("insn taken during call");
	eret_pc_a: assert property (eret |=> o_pc_we && o_pc_wdata == $past(i_rf_rdata_a) << 1)
		else $error("return pc wrong");
	cust_hold_a: assert property (o_cust_req.valid && !i_cust_done |=> $stable(o_cust_req))
		else $error("custom request changed");
	cust_write_a: assert property (o_cust_req.valid && i_cust_done |=> o_rf_we
		&& o_rf_wdata == $past(i_cust_result)) else $error("custom result lost");
endmodule
bind txd_exec txd_checker i_chk (.*);
`default_nettype wire

/* verification/txd_far_model.sv */
// Far-side model: handler table memory and user custom hardware
`default_nettype none
module txd_far_model
	import txd_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_slow,
	input wire logic i_vec_rd,
	input wire logic [TXD_DW-1:0] i_vec_addr,
	output logic o_vec_ack,
	output logic [TXD_DW-1:0] o_vec_rdata,
	input wire txd_cust_req_type i_cust_req,
	output logic o_cust_done,
	output logic [TXD_DW-1:0] o_cust_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] vcnt_q;
	logic [2:0] ccnt_q;
	wire logic [TXD_DW-1:0] word = i_vec_addr ^ 32'h5A5A_0000;
	wire logic [TXD_DW-1:0] res = i_cust_req.opa + i_cust_req.opb
		+ (i_cust_req.prefix_valid ? 32'(i_cust_req.prefix) : 32'h0);
	// Off-cycle data is inverted so a stale sample never looks right
	assign o_vec_rdata = o_vec_ack ? word : ~word;
	assign o_cust_result = o_cust_done ? res : ~res;
	always_ff @(posedge i_mclk) begin
		o_vec_ack <= i_rst_b && i_vec_rd && !o_vec_ack && vcnt_q >= (i_slow ? 3'h3 : 3'h0);
		vcnt_q <= (i_rst_b && i_vec_rd && !o_vec_ack) ? vcnt_q + 3'h1 : 3'h0;
	end
	always_ff @(posedge i_mclk) begin
		o_cust_done <= i_rst_b && i_cust_req.valid && !o_cust_done
			&& ccnt_q >= (i_slow ? 3'h4 : 3'h0);
		ccnt_q <= (i_rst_b && i_cust_req.valid && !o_cust_done) ? ccnt_q + 3'h1 : 3'h0;
	end
endmodule
`default_nettype wire

/* verification/trap_custom_ctl_xor_decode_tb.sv */
// Self-checking testbench for the trap/custom/control/xor executor
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module trap_custom_ctl_xor_decode_tb
	import txd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_b = 0, vld = 0, pv = 0, slow = 0;
	logic [15:0] insn = 0;
	logic [10:0] pf = 0, ci, cidx;
	logic [31:0] pc = 0, base = 0, wd, lk, pw, cw, st, ss, ex;
	logic [31:0] rf [32];
	logic [31:0] wdata, vaddr, vdata, pcw, cres, ctlw, status, sstat;
	logic [4:0] wa, rda, rdb, waddr;
	logic [5:0] num;
	logic ready, rdy, rf_we, vec_rd, vec_ack, pc_we, cust_done, ctl_we;
	txd_cust_req_type creq;
	int failures = 0, samples_checked = 0;
	always #4 clk = ~clk;
	txd_exec i_dut (.i_mclk(clk), .i_rst_b(rst_b), .i_insn_valid(vld), .i_insn(insn),
		.i_pc(pc), .i_prefix_valid(pv), .i_prefix(pf), .i_vec_base(base), .o_insn_ready(ready),
		.o_rf_raddr_a(rda), .o_rf_raddr_b(rdb), .i_rf_rdata_a(rf[rda]), .i_rf_rdata_b(rf[rdb]),
		.i_rf_rdata_r0(rf[0]), .o_rf_we(rf_we), .o_rf_waddr(waddr), .o_rf_wdata(wdata),
		.o_vec_rd(vec_rd), .o_vec_addr(vaddr), .i_vec_ack(vec_ack), .i_vec_rdata(vdata),
		.o_pc_we(pc_we), .o_pc_wdata(pcw), .o_cust_req(creq), .i_cust_done(cust_done),
		.i_cust_result(cres), .o_ctl_we(ctl_we), .o_ctl_idx(cidx), .o_ctl_wdata(ctlw),
		.o_status(status), .o_saved_status(sstat));
	txd_far_model i_far (.i_mclk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_vec_rd(vec_rd),
		.i_vec_addr(vaddr), .o_vec_ack(vec_ack), .o_vec_rdata(vdata), .i_cust_req(creq),
		.o_cust_done(cust_done), .o_cust_result(cres));
	task automatic run(input logic [15:0] op, input logic p, input logic [10:0] k);
		{wd, lk, pw, cw} = 'x;
		st = status;
		ss = sstat;
		{insn, pv, pf, vld} = {op, p, k, 1'b1};
		#1 rdy = ready;
		@(negedge clk);
		vld = 0;
		repeat (40) begin
			if (rf_we && waddr == 5'hF) lk = wdata;
			else if (rf_we) {wa, wd} = {waddr, wdata};
			if (pc_we) pw = pcw;
			if (ctl_we) {ci, cw} = {cidx, ctlw};
			if (pc_we || ctl_we || (rf_we && waddr != 5'hF)) break;
			@(negedge clk);
		end
		// Idle cycle lets status settle and stands in for the required no-operation
		@(negedge clk);
	endtask
	task automatic final_report;
		$display("checks=%0d failures=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		final_report;
	end
	initial begin
		for (int i = 0; i < 32; i++) rf[i] = 32'h1357_9BDF * (i + 1);
		{rf[2], rf[3], rf[4], rf[5]} = {32'h0000_8065, 32'hA, 32'h8000_00F0, 32'hF0};
		repeat (16) @(negedge clk);
		rst_b = 1;
		@(negedge clk);
		run({TXD_OP11_CTLWR, 5'd2}, 0, 0);
		`CHK(ci, TXD_CTL_STATUS)
		`CHK(status, rf[2])
		run({TXD_OP11_CTLWR, 5'd3}, 1, TXD_CTL_ISTAT);
		`CHK({ci, cw}, {TXD_CTL_ISTAT, rf[3]})
		`CHK(status[3:0], 4'h5)
		$display("control write test done");
		for (int b = 5; b >= 3; b--) begin
			ex = (b == 3) ? rf[4] ^ 32'h0000_FFFF : rf[4] ^ rf[b];
			run({TXD_OP6_XOR, b == 3 ? 5'h1F : 5'(b), 5'd4}, b == 3, 11'h7FF);
			`CHK({wa, wd}, {5'd4, ex})
			`CHK(rdy, 1'b1)
			`CHK(status[3:0], {ex[31], st[2], ex == 0, st[0]})
		end
		$display("xor test done");
		base = 32'h0000_4000;
		for (int j = 0; j < 2; j++) begin
			num = j ? 6'h3F : 6'h01;
			slow = j;
			pc = 32'h200 + 16 * j;
			run({TXD_OP10_TRAP, num}, 0, 0);
			`CHK(lk, (pc + 2) >> 1)
			`CHK(rdy, 1'b0)
			`CHK(pw, ((base + {num, 2'b00}) ^ 32'h5A5A_0000) << 1)
			`CHK(sstat, st)
			`CHK(status, {st[31:16], 1'b0, num, st[8:4] - 5'd1, st[3:0]})
		end
		$display("trap test done");
		rf[15] = lk;
		run({TXD_OP11_ERET, 5'hF}, 0, 0);
		`CHK(pw, rf[15] << 1)
		`CHK(status, ss)
		$display("return test done");
		for (int s = 0; s < 5; s++) begin
			slow = s[0];
			ex = rf[8] + (s == 0 ? rf[9] : rf[0]) + (s > 1 ? 32'h400 + s : 32'h0);
			run(s == 0 ? {TXD_OP6_CUST2, 5'd9, 5'd8} : {11'(TXD_OP11_CUST1 + s - 1), 5'd8},
				s > 1, 11'(11'h400 + s));
			`CHK({wa, wd}, {5'd8, ex})
			`CHK(status, st)
		end
		$display("custom test done");
		final_report;
	end
endmodule
`default_nettype wire
